// file: rtl/cfr_regs.sv
// chop and channel 0 configuration register bank on ahb-lite
// Notes on behaviour
// RL1: delay code bits 12:9 set settle wait of 2^(code+1) modulator periods, reset 0011b
// RL2: bit 8 enables global chopping; resets disabled
// RL3: chop configuration word at 06h resets to 0600h
// RL4: host writes zeros to chop word bits 15:13 and 7:0
// RL5: channel 0 selector 1:0: pins, shorted, positive test, negative test
// RL6: channel 0 word bits 5:3 read zero; host writes zero elsewhere reserved
// RL7: word 0Ah holds offset bits 23:8, resets zero
// RL8: word 0Bh holds offset bits 7:0 in 15:8; low byte reads zero
// RL9: reserved words 05h and 07h read/write, reset zero, host writes zeros
// RL10: word 08h bits 7:4 read zero; host writes zeros to other bits
// RL11: offset words join into signed 24-bit correction on channel 0 results
// RL12: with chopping on, discard conversions until delay passes after each swap
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "cfr_params.svh"
module cfr_regs
  import cfr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mod_tick,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  output logic [1:0] first_channel_input_select,
  output logic chop_polarity,
  output logic result_valid,
  output logic [23:0] result_data
);
  logic [15:0] reserved_slot_05_r;
  logic [15:0] chop_configuration_r;
  logic [15:0] reserved_slot_07_r;
  logic [15:0] reserved_slot_08_r;
  logic [15:0] first_channel_setup_r;
  logic [15:0] first_channel_offset_high_r;
  logic [15:0] first_channel_offset_low_r;
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [15:0] wd;
  logic rd_go;
  logic [7:0] idx;
  logic [31:0] rd_nxt;
  logic [15:0] ro_mask;
  logic wr_hit;
  logic chop_enable_bit;
  logic [3:0] chop_settle_delay;
  logic [23:0] ofs;
  logic accept;
  logic [23:0] result_r;
  logic [15:0] accept_cnt_r;
  cfr_mux_t first_channel_input_mux;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign idx = haddr[9:2];
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wd = hwdata[15:0];
  // write still in its data phase while a read samples the same word
  assign wr_hit = wr_pend_r && (wr_idx_r == idx);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wr_idx_r <= idx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; read-only bits are masked so they always hold zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reserved_slot_05_r <= `CFR_ZERO_RESET; // RL9
      chop_configuration_r <= `CFR_CHOP_RESET; // RL3
      reserved_slot_07_r <= `CFR_ZERO_RESET; // RL9
      reserved_slot_08_r <= `CFR_ZERO_RESET;
      first_channel_setup_r <= `CFR_ZERO_RESET;
      first_channel_offset_high_r <= `CFR_ZERO_RESET; // RL7
      first_channel_offset_low_r <= `CFR_ZERO_RESET;
    end else if (wr_pend_r) begin
      if (wr_idx_r == `CFR_IDX_RSV05) begin
        reserved_slot_05_r <= wd; // RL9
      end else if (wr_idx_r == `CFR_IDX_CHOP) begin
        // reserved bits stored as written; host keeps them zero
        chop_configuration_r <= wd; // RL4
      end else if (wr_idx_r == `CFR_IDX_RSV07) begin
        reserved_slot_07_r <= wd; // RL9
      end else if (wr_idx_r == `CFR_IDX_RSV08) begin
        reserved_slot_08_r <= wd & ~`CFR_RSV08_RO_MASK; // RL10
      end else if (wr_idx_r == `CFR_IDX_CH0_SETUP) begin
        first_channel_setup_r <= wd & ~`CFR_CH0_RO_MASK; // RL6
      end else if (wr_idx_r == `CFR_IDX_OFS_HIGH) begin
        first_channel_offset_high_r <= wd; // RL7
      end else if (wr_idx_r == `CFR_IDX_OFS_LOW) begin
        first_channel_offset_low_r <= wd & ~`CFR_LOW_RO_MASK; // RL8
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  assign chop_enable_bit = chop_configuration_r[`CFR_CHOP_EN_BIT]; // RL2
  assign chop_settle_delay = chop_configuration_r[`CFR_DLY_MSB:`CFR_DLY_LSB]; // RL1
  assign first_channel_input_mux = cfr_mux_t'(first_channel_setup_r[`CFR_MUX_MSB:0]);
  assign first_channel_input_select = first_channel_input_mux; // RL5
  assign ofs = {first_channel_offset_high_r, first_channel_offset_low_r[15:8]}; // RL11

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  cfr_chop_seq u_chop (
    .hclk(hclk),
    .hresetn(hresetn),
    .chop_en(chop_enable_bit),
    .dly_code(chop_settle_delay),
    .mod_tick(mod_tick),
    .conv_valid(conv_valid),
    .chop_polarity(chop_polarity),
    .accept(accept)
  );

  cfr_ofs_apply #(.W(24)) u_ofs (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(accept),
    .in_data(conv_data),
    .offset(ofs),
    .out_valid(result_valid),
    .out_data(result_data)
  );

  // last corrected result and accepted count, visible to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= 24'h000000;
      accept_cnt_r <= 16'h0000;
    end else if (result_valid) begin
      result_r <= result_data;
      accept_cnt_r <= accept_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped words read zero
  always_comb begin
    rd_nxt = 32'h00000000;
    ro_mask = 16'h0000;
    if (idx == `CFR_IDX_RSV05) begin
      rd_nxt = {16'h0000, reserved_slot_05_r};
    end else if (idx == `CFR_IDX_CHOP) begin
      rd_nxt = {16'h0000, chop_configuration_r};
    end else if (idx == `CFR_IDX_RSV07) begin
      rd_nxt = {16'h0000, reserved_slot_07_r};
    end else if (idx == `CFR_IDX_RSV08) begin
      ro_mask = `CFR_RSV08_RO_MASK;
      rd_nxt = {16'h0000, reserved_slot_08_r & ~`CFR_RSV08_RO_MASK}; // RL10
    end else if (idx == `CFR_IDX_CH0_SETUP) begin
      ro_mask = `CFR_CH0_RO_MASK;
      rd_nxt = {16'h0000, first_channel_setup_r & ~`CFR_CH0_RO_MASK}; // RL6
    end else if (idx == `CFR_IDX_OFS_HIGH) begin
      rd_nxt = {16'h0000, first_channel_offset_high_r};
    end else if (idx == `CFR_IDX_OFS_LOW) begin
      ro_mask = `CFR_LOW_RO_MASK;
      rd_nxt = {16'h0000, first_channel_offset_low_r & ~`CFR_LOW_RO_MASK}; // RL8
    end else if (idx == `CFR_IDX_RESULT) begin
      rd_nxt = {8'h00, result_r};
    end else if (idx == `CFR_IDX_STATUS) begin
      rd_nxt = {13'h0000, chop_polarity, chop_enable_bit, 1'b0, accept_cnt_r};
    end
    // back-to-back read would otherwise return the word before the write lands
    if (wr_hit && idx >= `CFR_IDX_RSV05 && idx <= `CFR_IDX_OFS_LOW) begin
      rd_nxt = {16'h0000, wd & ~ro_mask};
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_go) begin
      hrdata <= rd_nxt;
    end
  end
endmodule // cfr_regs

// file: rtl/cfr_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH
`define CFR_IDX_RSV05 8'h05
`define CFR_IDX_CHOP 8'h06
`define CFR_IDX_RSV07 8'h07
`define CFR_IDX_RSV08 8'h08
`define CFR_IDX_CH0_SETUP 8'h09
`define CFR_IDX_OFS_HIGH 8'h0A
`define CFR_IDX_OFS_LOW 8'h0B
`define CFR_IDX_RESULT 8'h20
`define CFR_IDX_STATUS 8'h21
`define CFR_CHOP_RESET 16'h0600
`define CFR_ZERO_RESET 16'h0000
`define CFR_CHOP_EN_BIT 8
`define CFR_DLY_LSB 9
`define CFR_DLY_MSB 12
`define CFR_MUX_MSB 1
`define CFR_RSV08_RO_MASK 16'h00F0
`define CFR_CH0_RO_MASK 16'h0038
`define CFR_LOW_RO_MASK 16'h00FF
`define CFR_DLY_MIN_PERIODS 2
`endif

// file: rtl/cfr_pkg.sv
// types shared by the chop and channel 0 configuration block
package cfr_pkg;
  typedef enum logic [1:0] {
    CFR_MUX_PINS = 2'h0,
    CFR_MUX_SHORT = 2'h1,
    CFR_MUX_TEST_POS = 2'h2,
    CFR_MUX_TEST_NEG = 2'h3
  } cfr_mux_t;
  typedef enum logic [2:0] {
    CFR_ST_IDLE = 3'b001,
    CFR_ST_SETTLE = 3'b010,
    CFR_ST_MEASURE = 3'b100
  } cfr_chop_st_t;
endpackage

// file: rtl/cfr_chop_seq.sv
// global chop sequencer: settle wait after each polarity swap
`timescale 1ns/1ps
`include "cfr_params.svh"
module cfr_chop_seq
  import cfr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic chop_en,
  input wire logic [3:0] dly_code,
  input wire logic mod_tick,
  input wire logic conv_valid,
  output logic chop_polarity,
  output logic accept
);
  cfr_chop_st_t state_r;
  logic [16:0] cnt_r;
  logic [16:0] target;
  // code n waits 2^(n+1) modulator periods
  assign target = 17'(`CFR_DLY_MIN_PERIODS) << dly_code; // RL1
  assign accept = chop_en ? (state_r == CFR_ST_MEASURE) && conv_valid : conv_valid; // RL12

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= CFR_ST_IDLE;
      cnt_r <= 17'h00000;
      chop_polarity <= 1'b0;
    end else if (!chop_en) begin
      state_r <= CFR_ST_IDLE;
      cnt_r <= 17'h00000;
      chop_polarity <= 1'b0;
    end else begin
      case (state_r)
        CFR_ST_IDLE: begin
          state_r <= CFR_ST_SETTLE;
          cnt_r <= 17'h00000;
        end
        CFR_ST_SETTLE: begin
          if (mod_tick) begin
            if (cnt_r + 17'h00001 >= target) begin
              state_r <= CFR_ST_MEASURE; // RL12
            end
            cnt_r <= cnt_r + 17'h00001;
          end
        end
        CFR_ST_MEASURE: begin
          // one accepted result per phase, then swap inputs and settle again
          if (conv_valid) begin
            chop_polarity <= ~chop_polarity;
            state_r <= CFR_ST_SETTLE;
            cnt_r <= 17'h00000;
          end
        end
        default: state_r <= CFR_ST_IDLE;
      endcase
    end
  end
endmodule // cfr_chop_seq

// file: rtl/cfr_ofs_apply.sv
// applies the signed 24-bit offset to channel 0 results
`timescale 1ns/1ps
module cfr_ofs_apply #(
  parameter int W = 24
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  input wire logic [W-1:0] offset,
  output logic out_valid,
  output logic [W-1:0] out_data
);
  logic signed [W:0] sum;
  logic signed [W-1:0] maxv;
  logic signed [W-1:0] minv;
  assign maxv = {1'b0, {(W-1){1'b1}}};
  assign minv = {1'b1, {(W-1){1'b0}}};
  assign sum = $signed({in_data[W-1], in_data}) + $signed({offset[W-1], offset}); // RL11

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid;
      // saturate rather than wrap at full scale
      if (in_valid) begin
        if (sum[W] != sum[W-1]) begin
          out_data <= sum[W] ? minv : maxv;
        end else begin
          out_data <= sum[W-1:0];
        end
      end
    end
  end
endmodule // cfr_ofs_apply

// file: dv/cfr_regs_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module cfr_regs_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] first_channel_input_select,
  input wire logic chop_polarity,
  input wire logic result_valid,
  input wire logic conv_valid
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_ap = hsel && hready && htrans[1] && !hwrite;
  logic wr09_r;
  // write address phase to the setup word, seen one edge later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr09_r <= 1'b0;
    else
      wr09_r <= hsel && hready && htrans[1] && hwrite && haddr[9:2] == 8'h09;
  end
  ////////////////////////////////////////
  property p_rd_hi; rd_ap && haddr[9:2] <= 8'h0B |=> hrdata[31:16] == 16'h0000; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read upper half not zero");
  property p_rd_low; rd_ap && haddr[9:2] == 8'h0B |=> hrdata[7:0] == 8'h00; endproperty
  a_rd_low: assert property (p_rd_low) else $error("offset low byte not zero");
  property p_rd_ch0;
    rd_ap && haddr[9:2] == 8'h09 |=> hrdata[5:3] == 3'h0 && hrdata[1:0] == first_channel_input_select;
  endproperty
  a_rd_ch0: assert property (p_rd_ch0) else $error("setup word readback wrong");
  property p_rd_rsv08; rd_ap && haddr[9:2] == 8'h08 |=> hrdata[7:4] == 4'h0; endproperty
  a_rd_rsv08: assert property (p_rd_rsv08) else $error("word 08 bits 7:4 not zero");
  property p_sel_src; $changed(first_channel_input_select) |-> $past(wr09_r); endproperty
  a_sel_src: assert property (p_sel_src) else $error("selector moved without write");
  property p_res_cause; result_valid |-> $past(conv_valid); endproperty
  a_res_cause: assert property (p_res_cause) else $error("result without conversion");
  property p_pol_res; $rose(chop_polarity) |-> result_valid; endproperty
  a_pol_res: assert property (p_pol_res) else $error("swap without accepted result");
  // shortest settle is two ticks, so two quiet cycles follow every swap that comes with a result
  property p_settle; $changed(chop_polarity) && result_valid |=> !result_valid [*2]; endproperty
  a_settle: assert property (p_settle) else $error("result inside settle wait");
  c_res: cover property (result_valid);
  c_swap: cover property ($rose(chop_polarity));
  c_rd_low: cover property (rd_ap && haddr[9:2] == 8'h0B);
endmodule // cfr_regs_props

// file: dv/cfr_mod_src.sv
// modulator side: tick every other cycle, one conversion per five cycles
`timescale 1ns/1ps
module cfr_mod_src (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  output logic mod_tick,
  output logic conv_valid,
  output logic [23:0] conv_data
);
  int seed = 89;
  logic [2:0] ph;
  // data inverted outside valid so a stale sample never looks right
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_tick <= 1'b0;
      conv_valid <= 1'b0;
      ph <= 3'h0;
      conv_data <= 24'h000000;
    end else begin
      mod_tick <= ~mod_tick;
      ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
      conv_valid <= go && ph == 3'h4;
      conv_data <= (go && ph == 3'h4) ? 24'($random(seed)) : ~conv_data;
    end
  end
endmodule // cfr_mod_src

// file: dv/tb_cfr_regs.sv
// self-checking bench for the chop and channel 0 register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_cfr_regs;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, pol_q = 0, gap_on = 0, chop_on = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] d;
  logic [3:0] code;
  logic [23:0] ofs = 0, last_conv = 0;
  int seed = 89, n_fail = 0, n_tests = 0, ticks = 0, need = 0, cyc = 0;
  logic [15:0] rstv [5:11] = '{16'h0, 16'h0600, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] wmask [5:11] = '{16'h0, 16'h1F00, 16'h0, 16'h00F0, 16'h003B, 16'hFFFF, 16'hFFFF};
  logic [15:0] rmask [5:11] = '{16'h0, 16'h1F00, 16'h0, 16'h0, 16'h0003, 16'hFFFF, 16'hFF00};
  wire logic hreadyout, hresp, mod_tick, conv_valid, chop_polarity, result_valid;
  wire logic [31:0] hrdata;
  wire logic [1:0] sel;
  wire logic [23:0] conv_data, result_data;
  cfr_regs cfr_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mod_tick(mod_tick),
    .conv_valid(conv_valid), .conv_data(conv_data), .first_channel_input_select(sel),
    .chop_polarity(chop_polarity), .result_valid(result_valid), .result_data(result_data));
  cfr_mod_src cfr_mod_src_i (.hclk(hclk), .hresetn(hresetn), .go(go), .mod_tick(mod_tick),
    .conv_valid(conv_valid), .conv_data(conv_data));
  initial forever #5 hclk = ~hclk;
  ////////////////////////////////////////
  function automatic logic [23:0] sat(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] s;
    s = {a[23], a} + {b[23], b};
    if (s[24] != s[23]) return s[24] ? 24'h800000 : 24'h7FFFFF;
    return s[23:0];
  endfunction
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // zero-wait slave, but the wait loops still honour hready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk_rd(input logic [7:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0);
    `CHK(rd, {16'h0, e})
    `CHK(hresp, 1'b0)
  endtask
  ////////////////////////////////////////
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      test_done();
    end
    if (conv_valid === 1'b1) last_conv <= conv_data;
    if (result_valid === 1'b1) `CHK(result_data, sat(last_conv, ofs))
    // swaps from turning chopping off, or across a code change, are not timed
    if (chop_polarity !== pol_q) begin
      if (gap_on && chop_on) `CHK(ticks >= need && ticks <= need + 4, 1'b1)
      gap_on <= chop_on;
      ticks <= int'(mod_tick);
    end else begin
      if (!chop_on) gap_on <= 1'b0;
      if (mod_tick === 1'b1) ticks <= ticks + 1;
    end
    pol_q <= chop_polarity;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 5; i < 12; i++) chk_rd(8'(i), rstv[i]);
    // host keeps reserved writable bits zero; read-only bits get random data
    for (int i = 5; i < 12; i++) begin
      d = 16'($random(seed)) & wmask[i];
      bus(1'b1, 8'(i), d);
      chk_rd(8'(i), d & rmask[i]);
    end
    // random fill may have left chopping on with a long delay
    bus(1'b1, 8'h06, 16'h0600);
    chk_rd(8'h40, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h09, 16'(m));
      @(negedge hclk);
      `CHK(sel, 2'(m))
    end
    for (int k = 0; k < 2; k++) begin
      ofs = k ? 24'($random(seed)) : 24'h7FFF80;
      bus(1'b1, 8'h0A, ofs[23:8]);
      bus(1'b1, 8'h0B, {ofs[7:0], 8'h00});
      go <= 1'b1;
      repeat (100) @(posedge hclk);
      go <= 1'b0;
      repeat (3) @(posedge hclk);
    end
    for (int c = 0; c < 3; c++) begin
      code = (c == 2) ? 4'h3 : 4'(c);
      chop_on = 1'b0;
      bus(1'b1, 8'h06, 16'h0600);
      repeat (8) @(posedge hclk);
      need = 2 << code;
      chop_on = 1'b1;
      bus(1'b1, 8'h06, {3'h0, code, 1'b1, 8'h00});
      go <= 1'b1;
      repeat (400) @(posedge hclk);
    end
    chop_on = 1'b0;
    go <= 1'b0;
    bus(1'b1, 8'h06, 16'h0600);
    repeat (3) @(negedge hclk);
    `CHK(chop_polarity, 1'b0)
    bus(1'b1, 8'h06, 16'h1E00);
    bus(1'b1, 8'h09, 16'h0003);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(8'h09, 16'h0000);
    chk_rd(8'h06, 16'h0600);
    test_done();
  end
endmodule // tb_cfr_regs
bind cfr_regs cfr_regs_props cfr_regs_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .first_channel_input_select(first_channel_input_select), .chop_polarity(chop_polarity),
  .result_valid(result_valid), .conv_valid(conv_valid));
